// ==== udma.v ====
// Eight-channel micro DMA engine with AHB-Lite register slave
// Function
// - DMA requests served at top level six
// - Requests stay pending while CPU halted
// - Eight channels, each with start vector
// - Accept clears the source pending flag
// - Move one block, decrement counter once
// - Nonzero count keeps start vector armed
// - Zero count: end irq, clear vector
// - Lowest channel number wins arbitration
// - Cleared vector returns source to controller
// - End irqs prioritised by interrupt controller
// - Only low 24 address bits driven
// - Addresses updated per channel mode
// - Sixteen-bit counter, zero means 65536
// - 39 vector sources plus software start
// - Prefetch, prefetch, read, write, prefetch
// - Writing one starts one transfer
// - Completed soft start clears its bit
// - Burst runs until counter reaches zero
// - Soft start on armed channel keeps counter
// - Mode bits 4..2 select address update
// - Mode bits 1..0 select transfer size
// - Burst end clears source pending flag
//
// The AHB-Lite slave port is this design's own decision.
`include "udma_defs.vh"
`default_nettype none

module udma #(
  parameter NCH = 8
) (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  // Interrupt controller side
  input wire [63:0] src_pending_i,
  input wire cpu_halted_i,
  output reg [63:0] src_clear_o,
  output reg [63:0] dma_owned_o,
  output reg dma_req_o,
  output reg [2:0] dma_level_o,
  output reg [7:0] end_irq_o,
  // CPU bus side
  input wire queue_full_i,
  output reg prefetch_o,
  output reg [23:0] mem_addr_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg [1:0] mem_size_o,
  output reg [31:0] mem_wdata_o,
  input wire [31:0] mem_rdata_i,
  input wire mem_ready_i
);

  // ---------------------------------------------------------------
  // Engine states
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_PF1 = 3'h1;
  localparam ST_PF2 = 3'h2;
  localparam ST_RD = 3'h3;
  localparam ST_WR = 3'h4;
  localparam ST_PF3 = 3'h5;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function vec_ok;
    input [7:0] v;
    begin
      vec_ok = (v >= `UDMA_VEC_MIN) && (v <= `UDMA_VEC_MAX);
    end
  endfunction

  function [31:0] step_of;
    input [1:0] sz;
    begin
      case (sz)
        `UDMA_SIZE_2: step_of = 32'h00000002;
        `UDMA_SIZE_4: step_of = 32'h00000004;
        default: step_of = 32'h00000001;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  reg [7:0] vec_q [0:NCH-1];
  reg [31:0] src_q [0:NCH-1];
  reg [31:0] dst_q [0:NCH-1];
  reg [15:0] cnt_q [0:NCH-1];
  reg [4:0] mode_q [0:NCH-1];
  reg [7:0] swreq_q;
  reg [7:0] burst_q;
  reg [2:0] st_q;
  reg [2:0] ch_q;
  reg sw_q;
  reg hold_q;
  reg [7:0] cvec_q;
  reg [9:0] aidx_q;
  reg wr_pend_q;
  reg rd_pend_q;
  integer n;
  integer ni;
  integer no;

  // ---------------------------------------------------------------
  // Request collection and fixed-priority pick
  // ---------------------------------------------------------------
  reg [7:0] hw_req;
  reg [7:0] any_req;
  reg [2:0] pick;
  reg [7:0] pv;
  always @* begin
    hw_req = 8'h00;
    pick = 3'h0;
    pv = 8'h00;
    for (ni = 0; ni < NCH; ni = ni + 1) begin
      pv = vec_q[ni];
      hw_req[ni] = vec_ok(pv) && src_pending_i[pv[5:0]];
    end
    any_req = hw_req | swreq_q;
    // Scan downwards so the lowest requesting channel is kept
    for (ni = NCH - 1; ni >= 0; ni = ni - 1) begin
      if (any_req[ni]) begin
        pick = ni[2:0];
      end
    end
    pv = vec_q[pick];
  end

  // ---------------------------------------------------------------
  // End-of-transfer arithmetic for the active channel
  // ---------------------------------------------------------------
  reg [15:0] cnt_nx;
  reg [31:0] src_nx;
  reg [31:0] dst_nx;
  reg [31:0] stp;
  reg [2:0] upd;
  reg last;
  always @* begin
    upd = mode_q[ch_q][`UDMA_MODE_UPD_MSB:`UDMA_MODE_UPD_LSB];
    stp = step_of(mode_q[ch_q][`UDMA_MODE_SIZE_MSB:`UDMA_MODE_SIZE_LSB]);
    cnt_nx = hold_q ? cnt_q[ch_q] : cnt_q[ch_q] - 16'h0001;
    last = !hold_q && (cnt_nx == 16'h0000);
    src_nx = src_q[ch_q];
    dst_nx = dst_q[ch_q];
    // Counter mode steps the source by one whatever the size
    case (upd)
      `UDMA_UPD_DST_INC: dst_nx = dst_q[ch_q] + stp;
      `UDMA_UPD_DST_DEC: dst_nx = dst_q[ch_q] - stp;
      `UDMA_UPD_SRC_INC: src_nx = src_q[ch_q] + stp;
      `UDMA_UPD_SRC_DEC: src_nx = src_q[ch_q] - stp;
      `UDMA_UPD_BOTH_INC: begin
        src_nx = src_q[ch_q] + stp;
        dst_nx = dst_q[ch_q] + stp;
      end
      `UDMA_UPD_BOTH_DEC: begin
        src_nx = src_q[ch_q] - stp;
        dst_nx = dst_q[ch_q] - stp;
      end
      `UDMA_UPD_COUNTER: src_nx = src_q[ch_q] + 32'h00000001;
      default: src_nx = src_q[ch_q];
    endcase
  end

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  reg [31:0] rdata_c;
  always @* begin
    rdata_c = 32'h00000000;
    if (aidx_q == `UDMA_IDX_SWREQ) begin
      rdata_c = {24'h000000, swreq_q};
    end else if (aidx_q == `UDMA_IDX_BURST) begin
      rdata_c = {24'h000000, burst_q};
    end else if (aidx_q == `UDMA_IDX_STATUS) begin
      rdata_c = {25'h0000000, st_q != ST_IDLE, 3'h0, ch_q};
    end else if (aidx_q[9:3] == `UDMA_IDX_VEC >> 3) begin
      rdata_c = {24'h000000, vec_q[aidx_q[2:0]]};
    end else if (aidx_q[9:3] == `UDMA_IDX_SRC >> 3) begin
      rdata_c = src_q[aidx_q[2:0]];
    end else if (aidx_q[9:3] == `UDMA_IDX_DST >> 3) begin
      rdata_c = dst_q[aidx_q[2:0]];
    end else if (aidx_q[9:3] == `UDMA_IDX_CNT >> 3) begin
      rdata_c = {16'h0000, cnt_q[aidx_q[2:0]]};
    end else if (aidx_q[9:3] == `UDMA_IDX_MODE >> 3) begin
      rdata_c = {27'h0000000, mode_q[aidx_q[2:0]]};
    end
  end

  // ---------------------------------------------------------------
  // Source ownership map for the interrupt controller
  // ---------------------------------------------------------------
  reg [63:0] owned_c;
  always @* begin
    owned_c = 64'h0000000000000000;
    // An owned source raises no ordinary interrupt in the controller
    for (no = 0; no < NCH; no = no + 1) begin
      if (vec_ok(vec_q[no])) begin
        owned_c[vec_q[no][5:0]] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Engine, bus slave and register file
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (n = 0; n < NCH; n = n + 1) begin
        vec_q[n] <= `UDMA_VEC_RST;
        src_q[n] <= `UDMA_ADDR_RST;
        dst_q[n] <= `UDMA_ADDR_RST;
        cnt_q[n] <= `UDMA_CNT_RST;
        mode_q[n] <= `UDMA_MODE_RST;
      end
      swreq_q <= `UDMA_SWREQ_RST;
      burst_q <= `UDMA_BURST_RST;
      st_q <= ST_IDLE;
      ch_q <= 3'h0;
      sw_q <= 1'b0;
      hold_q <= 1'b0;
      cvec_q <= 8'h00;
      aidx_q <= 10'h000;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      src_clear_o <= 64'h0000000000000000;
      dma_owned_o <= 64'h0000000000000000;
      dma_req_o <= 1'b0;
      dma_level_o <= `UDMA_DMA_LEVEL;
      end_irq_o <= 8'h00;
      prefetch_o <= 1'b0;
      mem_addr_o <= 24'h000000;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_size_o <= 2'h0;
      mem_wdata_o <= 32'h00000000;
    end else begin
      src_clear_o <= 64'h0000000000000000;
      end_irq_o <= 8'h00;
      prefetch_o <= 1'b0;
      dma_owned_o <= owned_c;
      dma_level_o <= `UDMA_DMA_LEVEL;
      dma_req_o <= (st_q != ST_IDLE) || (|any_req && !cpu_halted_i);
      case (st_q)
        ST_IDLE: begin
          if (|any_req && !cpu_halted_i) begin
            ch_q <= pick;
            cvec_q <= pv;
            st_q <= ST_PF1;
            // A hardware start outranks a soft start on the same channel
            if (hw_req[pick]) begin
              src_clear_o[pv[5:0]] <= 1'b1;
              sw_q <= 1'b0;
              hold_q <= 1'b0;
            end else begin
              sw_q <= 1'b1;
              hold_q <= vec_ok(pv);
            end
          end
        end
        ST_PF1: begin
          prefetch_o <= !queue_full_i;
          st_q <= ST_PF2;
        end
        ST_PF2: begin
          prefetch_o <= !queue_full_i;
          if (upd == `UDMA_UPD_COUNTER) begin
            st_q <= ST_PF3;
          end else begin
            mem_rd_o <= 1'b1;
            mem_addr_o <= src_q[ch_q][`UDMA_ADDR_BITS-1:0];
            mem_size_o <= mode_q[ch_q][`UDMA_MODE_SIZE_MSB:`UDMA_MODE_SIZE_LSB];
            st_q <= ST_RD;
          end
        end
        ST_RD: begin
          if (mem_ready_i) begin
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b1;
            mem_addr_o <= dst_q[ch_q][`UDMA_ADDR_BITS-1:0];
            mem_wdata_o <= mem_rdata_i;
            st_q <= ST_WR;
          end
        end
        ST_WR: begin
          if (mem_ready_i) begin
            mem_wr_o <= 1'b0;
            st_q <= ST_PF3;
          end
        end
        ST_PF3: begin
          prefetch_o <= !queue_full_i;
          cnt_q[ch_q] <= cnt_nx;
          src_q[ch_q] <= src_nx;
          dst_q[ch_q] <= dst_nx;
          if (sw_q) begin
            swreq_q[ch_q] <= 1'b0;
          end
          if (last) begin
            end_irq_o[ch_q] <= 1'b1;
            vec_q[ch_q] <= `UDMA_VEC_RST;
            if (burst_q[ch_q] && vec_ok(cvec_q)) begin
              src_clear_o[cvec_q[5:0]] <= 1'b1;
            end
          end
          // Soft starts never burst
          if (burst_q[ch_q] && !last && !hold_q && !sw_q) begin
            st_q <= ST_PF1;
          end else begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      // AHB-Lite data phase: reads take one wait state
      if (rd_pend_q) begin
        hrdata_o <= rdata_c;
        hreadyout_o <= 1'b1;
        rd_pend_q <= 1'b0;
      end
      if (wr_pend_q) begin
        wr_pend_q <= 1'b0;
        // A bit set by the bus beats the engine's clear in the same cycle
        if (aidx_q == `UDMA_IDX_SWREQ) begin
          swreq_q <= swreq_q & ~((st_q == ST_PF3 && sw_q) ? (8'h01 << ch_q) : 8'h00)
            | hwdata_i[7:0];
        end else if (aidx_q == `UDMA_IDX_BURST) begin
          burst_q <= hwdata_i[7:0];
        end else if (aidx_q[9:3] == `UDMA_IDX_VEC >> 3) begin
          vec_q[aidx_q[2:0]] <= hwdata_i[7:0];
        end else if (aidx_q[9:3] == `UDMA_IDX_SRC >> 3) begin
          src_q[aidx_q[2:0]] <= hwdata_i;
        end else if (aidx_q[9:3] == `UDMA_IDX_DST >> 3) begin
          dst_q[aidx_q[2:0]] <= hwdata_i;
        end else if (aidx_q[9:3] == `UDMA_IDX_CNT >> 3) begin
          cnt_q[aidx_q[2:0]] <= hwdata_i[15:0];
        end else if (aidx_q[9:3] == `UDMA_IDX_MODE >> 3) begin
          mode_q[aidx_q[2:0]] <= hwdata_i[4:0];
        end
      end
      // AHB-Lite address phase
      if (hsel_i && htrans_i[1] && hready_i) begin
        aidx_q <= haddr_i[11:2];
        wr_pend_q <= hwrite_i;
        rd_pend_q <= !hwrite_i;
        hreadyout_o <= hwrite_i;
      end
    end
  end

endmodule

`default_nettype wire

// ==== udma_defs.vh ====
// Register indices, field positions, reset values and constants of the micro DMA engine
`ifndef UDMA_DEFS_VH
`define UDMA_DEFS_VH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define UDMA_IDX_SWREQ 10'h109
`define UDMA_IDX_BURST 10'h10a
`define UDMA_IDX_STATUS 10'h10b
`define UDMA_IDX_VEC 10'h110
`define UDMA_IDX_SRC 10'h118
`define UDMA_IDX_DST 10'h120
`define UDMA_IDX_CNT 10'h128
`define UDMA_IDX_MODE 10'h130

// ---------------------------------------------------------------
// Field positions and codes
// ---------------------------------------------------------------
`define UDMA_MODE_SIZE_MSB 1
`define UDMA_MODE_SIZE_LSB 0
`define UDMA_MODE_UPD_MSB 4
`define UDMA_MODE_UPD_LSB 2
`define UDMA_UPD_DST_INC 3'h0
`define UDMA_UPD_DST_DEC 3'h1
`define UDMA_UPD_SRC_INC 3'h2
`define UDMA_UPD_SRC_DEC 3'h3
`define UDMA_UPD_BOTH_INC 3'h4
`define UDMA_UPD_BOTH_DEC 3'h5
`define UDMA_UPD_FIXED 3'h6
`define UDMA_UPD_COUNTER 3'h7
`define UDMA_SIZE_1 2'h0
`define UDMA_SIZE_2 2'h1
`define UDMA_SIZE_4 2'h2

// ---------------------------------------------------------------
// Reset values and fixed figures
// ---------------------------------------------------------------
`define UDMA_SWREQ_RST 8'h00
`define UDMA_BURST_RST 8'h00
`define UDMA_VEC_RST 8'h00
`define UDMA_MODE_RST 5'h00
`define UDMA_CNT_RST 16'h0000
`define UDMA_ADDR_RST 32'h00000000
`define UDMA_VEC_MIN 8'h0a
`define UDMA_VEC_MAX 8'h30
`define UDMA_DMA_LEVEL 3'h6
`define UDMA_ADDR_BITS 24

`endif

// ==== udma_chk.sv ====
// Port checker of the micro DMA engine
`default_nettype none
module udma_chk (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Engine
  input wire logic cpu_halted_i,
  input wire logic queue_full_i,
  input wire logic prefetch_o,
  input wire logic [63:0] src_clear_o,
  input wire logic dma_req_o,
  input wire logic [2:0] dma_level_o,
  input wire logic [7:0] end_irq_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [1:0] mem_size_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_level_six: assert property (dma_level_o == 3'h6)
    else $error("request level not six");
  a_halt_holds: assert property (cpu_halted_i [*3] |-> !$rose(dma_req_o))
    else $error("request accepted while halted");
  a_clear_pulse: assert property (|src_clear_o |=> src_clear_o == 64'h0)
    else $error("source clear longer than one cycle");
  a_end_pulse: assert property (|end_irq_o |-> $onehot(end_irq_o) ##1 end_irq_o == 8'h0)
    else $error("end interrupt not a single pulse");
  a_rd_hold: assert property (mem_rd_o && !mem_ready_i |=> mem_rd_o && $stable(mem_addr_o))
    else $error("read dropped before ready");
  a_rd_to_wr: assert property (mem_rd_o && mem_ready_i |=> mem_wr_o && !mem_rd_o)
    else $error("write state does not follow read");
  a_wr_data: assert property (mem_rd_o && mem_ready_i |=> mem_wdata_o == $past(mem_rdata_i))
    else $error("written data differs from read data");
  a_mem_in_dma: assert property (mem_rd_o || mem_wr_o |-> dma_req_o)
    else $error("memory cycle outside transfer");
  a_read_wait: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i |=>
    !hreadyout_o ##1 hreadyout_o) else $error("read wait not one cycle");
  a_resp_okay: assert property (!hresp_o) else $error("bus response not okay");
  a_prefetch_dummy: assert property (prefetch_o |-> !$past(queue_full_i) && dma_req_o)
    else $error("prefetch issued while queue full");
  a_size_legal: assert property (mem_rd_o |-> mem_size_o != 2'h3)
    else $error("reserved transfer size on bus");
endmodule

bind udma udma_chk i_udma_chk (.clk_i, .sys_rst_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
  .hreadyout_o, .hresp_o, .cpu_halted_i, .queue_full_i, .prefetch_o, .src_clear_o, .dma_req_o,
  .dma_level_o, .end_irq_o, .mem_rd_o, .mem_wr_o, .mem_size_o, .mem_addr_o, .mem_wdata_o,
  .mem_rdata_i, .mem_ready_i);
`default_nettype wire

// ==== udma_mem.sv ====
// Memory and source flag model facing the micro DMA engine
`default_nettype none
module udma_mem (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Engine side
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [23:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [63:0] clear_i,
  input wire logic [63:0] set_i,
  input wire logic slow_i,
  output var logic [31:0] rdata_o,
  output var logic ready_o,
  output var logic [63:0] pend_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] dly_q;
  logic [23:0] wa;
  logic [31:0] wd;
  int nwr;
  always @(posedge clk_i) begin
    ready_o <= 1'b0;
    rdata_o <= ~rdata_o;
    pend_o <= (pend_o | set_i) & ~clear_i;
    if (sys_rst_i) begin
      pend_o <= 64'h0;
      rdata_o <= 32'h0;
      dly_q <= 2'h0;
      nwr <= 0;
    end else if ((rd_i || wr_i) && !ready_o) begin
      if (dly_q != 2'h0) begin
        dly_q <= dly_q - 2'h1;
      end else begin
        ready_o <= 1'b1;
        rdata_o <= {8'ha5, addr_i};
        dly_q <= slow_i ? 2'h2 : 2'h0;
        if (wr_i) begin
          wa <= addr_i;
          wd <= wdata_i;
          nwr <= nwr + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test_udma.sv ====
// Self-checking testbench of the micro DMA engine
`default_nettype none
`include "udma_defs.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module test_udma;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, hsel_i = 1'b1, hwrite_i = 1'b0;
  logic cpu_halted_i = 1'b0, queue_full_i = 1'b0, slow = 1'b0, wipe = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [63:0] pset = 64'h0, clr_seen = 64'h0;
  logic [7:0] end_seen = 8'h0;
  wire hready_i, hreadyout_o, hresp_o, dma_req_o, prefetch_o, mem_rd_o, mem_wr_o, mem_ready_i;
  wire [31:0] hrdata_o, mem_rdata_i, mem_wdata_o;
  wire [63:0] src_pending_i, src_clear_o, dma_owned_o;
  wire [2:0] dma_level_o;
  wire [7:0] end_irq_o;
  wire [23:0] mem_addr_o;
  wire [1:0] mem_size_o;
  int seed = 33, bad_count = 0, samples_checked = 0;
  assign hready_i = hreadyout_o;
  udma i_udma (.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .src_pending_i, .cpu_halted_i, .src_clear_o,
    .dma_owned_o, .dma_req_o, .dma_level_o, .end_irq_o, .queue_full_i, .prefetch_o, .mem_addr_o,
    .mem_rd_o, .mem_wr_o, .mem_size_o, .mem_wdata_o, .mem_rdata_i, .mem_ready_i);
  udma_mem i_udma_mem (.clk_i, .sys_rst_i, .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .clear_i(src_clear_o), .set_i(pset), .slow_i(slow),
    .rdata_o(mem_rdata_i), .ready_o(mem_ready_i), .pend_o(src_pending_i));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    queue_full_i <= 1'($random(seed));
    slow <= 1'($random(seed));
    clr_seen <= (wipe ? 64'h0 : clr_seen) | src_clear_o;
    end_seen <= (wipe ? 8'h0 : end_seen) | end_irq_o;
  end
  task automatic print_verdict;
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wt_rdy(output logic [31:0] q);
    int k = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1 && k < 40) begin @(posedge clk_i); k++; end
    q = hrdata_o;
    if (hreadyout_o !== 1'b1) begin bad_count++; print_verdict(); end
  endtask
  task automatic ahb(input logic w, input logic [9:0] ix, input logic [31:0] d,
    output logic [31:0] q);
    htrans_i <= 2'h2;
    haddr_i <= {20'h0, ix, 2'h0};
    hwrite_i <= w;
    wt_rdy(q);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wt_rdy(q);
  endtask
  task automatic wr(input int ix, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, 10'(ix), d, q);
  endtask
  task automatic rd(input int ix, output logic [31:0] q);
    ahb(1'b0, 10'(ix), 32'h0, q);
  endtask
  task automatic poll_sw;
    logic [31:0] q;
    int k = 0;
    do begin rd(`UDMA_IDX_SWREQ, q); k++; end while (q !== 32'h0 && k < 30);
    `CHK(q, 32'h0)
    if (q !== 32'h0) print_verdict();
  endtask
  task automatic hit(input logic [63:0] m);
    @(posedge clk_i);
    pset <= m;
    wipe <= 1'b1;
    @(posedge clk_i);
    pset <= 64'h0;
    wipe <= 1'b0;
  endtask
  task automatic wt_wr(input int n);
    int k = 0;
    while (i_udma_mem.nwr < n && k < 300) begin @(posedge clk_i); k++; end
    repeat (4) @(posedge clk_i);
    if (k >= 300) begin bad_count++; print_verdict(); end
  endtask
  function automatic logic [63:0] upd(input logic [2:0] m, input logic [1:0] z,
    input logic [31:0] s, input logic [31:0] d);
    logic [31:0] t;
    t = 32'h1 << z;
    if (m == 3'h7) s = s + 32'h1;
    if (m == 3'h2 || m == 3'h4) s = s + t;
    if (m == 3'h3 || m == 3'h5) s = s - t;
    if (m == 3'h0 || m == 3'h4) d = d + t;
    if (m == 3'h1 || m == 3'h5) d = d - t;
    return {s, d};
  endfunction
  initial begin
    logic [31:0] q, s, d;
    logic [63:0] e;
    logic [15:0] c;
    logic [1:0] z;
    int n, n0;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`UDMA_IDX_SWREQ, q);
    `CHK(q, 32'h0)
    rd(10'h0ff, q);
    `CHK(q, 32'h0)
    // ----------
    // Soft start per channel, each with its own update mode
    // ----------
    for (n = 0; n < 8; n++) begin
      s = $random(seed);
      d = $random(seed);
      c = (n == 7) ? 16'h0 : 16'($random(seed));
      z = 2'({$random(seed)} % 3);
      wr(`UDMA_IDX_SRC + n, s);
      wr(`UDMA_IDX_DST + n, d);
      wr(`UDMA_IDX_CNT + n, {16'h0, c});
      wr(`UDMA_IDX_MODE + n, {27'h0, n[2:0], z});
      n0 = i_udma_mem.nwr;
      wr(`UDMA_IDX_SWREQ, 32'h1 << n);
      poll_sw();
      e = upd(n[2:0], z, s, d);
      if (n != 7) `CHK(i_udma_mem.wa, d[23:0])
      if (n != 7) `CHK(i_udma_mem.wd, {8'ha5, s[23:0]})
      if (n == 7) `CHK(i_udma_mem.nwr, n0)
      rd(`UDMA_IDX_SRC + n, q);
      `CHK(q, e[63:32])
      rd(`UDMA_IDX_DST + n, q);
      `CHK(q, e[31:0])
      rd(`UDMA_IDX_CNT + n, q);
      `CHK(q, {16'h0, c - 16'h1})
    end
    // ----------
    // Interrupt starts, arming, end and disarm
    // ----------
    wr(`UDMA_IDX_VEC + 3, 32'h30);
    wr(`UDMA_IDX_CNT + 3, 32'h2);
    n0 = i_udma_mem.nwr;
    hit(64'h1 << 8'h30);
    wt_wr(n0 + 1);
    `CHK(clr_seen, 64'h1 << 8'h30)
    `CHK(end_seen, 8'h0)
    rd(`UDMA_IDX_VEC + 3, q);
    `CHK(q, 32'h30)
    hit(64'h1 << 8'h30);
    wt_wr(n0 + 2);
    `CHK(end_seen, 8'h08)
    rd(`UDMA_IDX_VEC + 3, q);
    `CHK(q, 32'h0)
    hit(64'h1 << 8'h30);
    repeat (20) @(posedge clk_i);
    `CHK(i_udma_mem.nwr, n0 + 2)
    `CHK(dma_owned_o[8'h30], 1'b0)
    wr(`UDMA_IDX_VEC + 1, 32'h0a);
    wr(`UDMA_IDX_VEC + 5, 32'h1f);
    wr(`UDMA_IDX_CNT + 1, 32'h1);
    wr(`UDMA_IDX_CNT + 5, 32'h1);
    wr(`UDMA_IDX_DST + 1, 32'h123400);
    wr(`UDMA_IDX_DST + 5, 32'h567800);
    hit((64'h1 << 8'h0a) | (64'h1 << 8'h1f));
    wt_wr(n0 + 3);
    `CHK(i_udma_mem.wa, 24'h123400)
    wt_wr(n0 + 4);
    `CHK(i_udma_mem.wa, 24'h567800)
    `CHK(end_seen, 8'h22)
    // ----------
    // Halted hold, then burst to zero
    // ----------
    wr(`UDMA_IDX_VEC + 4, 32'h22);
    wr(`UDMA_IDX_CNT + 4, 32'h3);
    wr(`UDMA_IDX_BURST, 32'h10);
    cpu_halted_i <= 1'b1;
    hit(64'h1 << 8'h22);
    repeat (20) @(posedge clk_i);
    `CHK(i_udma_mem.nwr, n0 + 4)
    cpu_halted_i <= 1'b0;
    wt_wr(n0 + 7);
    `CHK(end_seen, 8'h10)
    rd(`UDMA_IDX_CNT + 4, q);
    `CHK(q, 32'h0)
    wr(`UDMA_IDX_VEC + 2, 32'h11);
    wr(`UDMA_IDX_CNT + 2, 32'h5);
    wr(`UDMA_IDX_SWREQ, 32'h4);
    poll_sw();
    rd(`UDMA_IDX_CNT + 2, q);
    `CHK(q, 32'h5)
    print_verdict();
  end
endmodule
`default_nettype wire
